// >>> common/pea_pkg.sv
// Constants and types shared by the per-phase energy accumulators.
// Assumes one 10 MHz clock and 16-bit signed ADC samples per phase.
`default_nettype none
package pea_pkg;
  localparam int PHASES = 3;
  localparam int SAMPLE_W = 16;
  localparam int ENERGY_W = 32;
  localparam int ADDR_W = 12;
  localparam int CMD_BITS = 16;
  localparam int DATA_BITS = 32;
  localparam int CNT_W = 6;
  // One energy LSB is full scale V times full scale I times frame time / 2^16
  localparam int ENERGY_SHIFT = 14;
  // Per-cycle quantities
  localparam int CYCLES = 6;
  localparam int CYC_WATT = 0;
  localparam int CYC_VAR = 1;
  localparam int CYC_VA = 2;
  localparam int CYC_FWATT = 3;
  localparam int CYC_FVAR = 4;
  localparam int CYC_FVA = 5;
  // Long-term totals, also the bit order of the overflow flags
  localparam int TOTALS = 7;
  localparam int TOT_WATT_POS = 0;
  localparam int TOT_WATT_NEG = 1;
  localparam int TOT_VAR_POS = 2;
  localparam int TOT_VAR_NEG = 3;
  localparam int TOT_FVAR_POS = 4;
  localparam int TOT_FVAR_NEG = 5;
  localparam int TOT_FVA = 6;
  typedef logic [ENERGY_W-1:0] pea_word_t;
  typedef logic signed [SAMPLE_W-1:0] pea_sample_t;
  typedef logic [ADDR_W-1:0] pea_addr_t;
  typedef logic [TOTALS-1:0] pea_flags_t;
  typedef enum logic [1:0] {
    SPI_IDLE = 2'b00,
    SPI_CMD = 2'b01,
    SPI_DATA = 2'b10
  } pea_spi_state_t;
  localparam pea_word_t WORD_RESET = 32'h0000_0000;
  localparam pea_flags_t FLAGS_RESET = 7'h00;
  // Fixed register offsets per phase
  localparam pea_addr_t OFF_CYC_WATT [PHASES] = '{12'h1d0, 12'h2bc, 12'h3a8};
  localparam pea_addr_t OFF_CYC_VAR [PHASES] = '{12'h1d4, 12'h2c0, 12'h3ac};
  localparam pea_addr_t OFF_CYC_VA [PHASES] = '{12'h1d8, 12'h2c4, 12'h3b0};
  localparam pea_addr_t OFF_CYC_FWATT [PHASES] = '{12'h1dc, 12'h2c8, 12'h3b4};
  localparam pea_addr_t OFF_FVAR_NEG [PHASES] = '{12'h208, 12'h2f4, 12'h3f0};
  localparam pea_addr_t OFF_FVA [PHASES] = '{12'h20c, 12'h2f8, 12'h3e4};
  // Further per-phase registers: base + phase * stride + item
  localparam pea_addr_t OFF_EXTRA_BASE = 12'h900;
  localparam pea_addr_t OFF_PHASE_STRIDE = 12'h040;
  localparam pea_addr_t OFF_WATT_POS = 12'h000;
  localparam pea_addr_t OFF_WATT_NEG = 12'h004;
  localparam pea_addr_t OFF_VAR_POS = 12'h008;
  localparam pea_addr_t OFF_VAR_NEG = 12'h00c;
  localparam pea_addr_t OFF_FVAR_POS = 12'h010;
  localparam pea_addr_t OFF_CYC_FVAR = 12'h014;
  localparam pea_addr_t OFF_CYC_FVA = 12'h018;
  localparam pea_addr_t OFF_FLAGS = 12'h01c;
endpackage
`default_nettype wire

// >>> common/pea_acc_if.sv
// Link between the phase logic and one long-term total.
// Assumes the pea_pkg package is compiled first.
`default_nettype none
interface pea_acc_if;
  import pea_pkg::*;
  logic addEn;
  pea_word_t incr;
  pea_word_t total;
  logic overflow;
  modport acc (input addEn, input incr, output total, output overflow);
  modport ctl (output addEn, output incr, input total, input overflow);
endinterface
`default_nettype wire

// >>> logic/pea_total_acc.sv
// One unsigned 32-bit long-term energy total with carry-out detection.
// Assumes increments arrive as one-cycle enables from the phase logic.
`default_nettype none
module pea_total_acc (
  input wire logic ref_clk,
  input wire logic nrst,
  pea_acc_if.acc port
);
  import pea_pkg::*;

  pea_word_t total_r;
  logic [ENERGY_W:0] sum;

  assign sum = {1'b0, total_r} + {1'b0, port.incr};
  assign port.total = total_r;
  // Carry out of the top bit marks a wrap
  assign port.overflow = port.addEn & sum[ENERGY_W];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      total_r <= WORD_RESET;
    end else if (port.addEn) begin
      total_r <= sum[ENERGY_W-1:0];
    end
  end
endmodule
`default_nettype wire

// >>> logic/pea_energy_top.sv
// Per-phase energy accumulation with a serial read port for the host.
// Assumes sample, cycle-end and serial pins are synchronous to ref_clk.
//
// What this block does
// - Each DSP cycle, negative fundamental var magnitude joins the negative fund var total.
// - Negative fundamental var total wrapping sets its overflow flag.
// - Each DSP cycle, fundamental VA energy joins the fundamental VA total.
// - Fundamental VA total wrapping sets its overflow flag.
// - Low-power mode: no energy summing; current magnitudes feed the VA total.
// - Every sample adds instantaneous real power to the running real sum.
// - Cycle end copies the real sum, then steers it into positive or negative total.
// - Every sample adds instantaneous reactive power to the running var sum.
// - Cycle end copies the var sum, then steers it into positive or negative total.
// - A per-cycle register holds the latest cycle's raw VA energy.
// - A per-cycle register holds the latest cycle's fundamental real energy.
// - Energy LSB is full scale voltage times current times frame time over 2^16.
// - Energy registers are 32 bits, byte 3 high down to byte 0 low.
// - Positive fundamental var joins its total each cycle; wrapping sets its flag.
`default_nettype none
module pea_energy_top (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic sampleValid,
  input wire logic cycleEnd,
  input wire logic lowPower,
  input wire pea_pkg::pea_sample_t voltSample [pea_pkg::PHASES],
  input wire pea_pkg::pea_sample_t ampSample [pea_pkg::PHASES],
  input wire pea_pkg::pea_sample_t voltQuadSample [pea_pkg::PHASES],
  input wire pea_pkg::pea_sample_t voltFundSample [pea_pkg::PHASES],
  input wire pea_pkg::pea_sample_t ampFundSample [pea_pkg::PHASES],
  input wire pea_pkg::pea_sample_t voltFundQuadSample [pea_pkg::PHASES],
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  output logic spiMisoDrvN
);
  import pea_pkg::*;

  // Cycle pipeline and serial port state
  logic postCycle_r;
  logic spiClkPrev_r;
  pea_spi_state_t spiState_r;
  pea_spi_state_t spiState_nxt;
  logic [CNT_W-1:0] bitCnt_r;
  logic [CNT_W-1:0] bitCnt_nxt;
  logic [CMD_BITS-1:0] cmdShift_r;
  pea_word_t dataShift_r;
  pea_word_t dataShift_nxt;

  // Per-phase storage and links
  logic signed [ENERGY_W-1:0] sum_r [PHASES][CYCLES];
  logic signed [ENERGY_W-1:0] cyc_r [PHASES][CYCLES];
  logic signed [ENERGY_W-1:0] sampleInc [PHASES][CYCLES];
  pea_flags_t flags_r [PHASES];
  logic addEn [PHASES][TOTALS];
  pea_word_t incr [PHASES][TOTALS];
  pea_word_t total [PHASES][TOTALS];
  logic overflow [PHASES][TOTALS];
  pea_word_t phaseWord [PHASES];
  logic flagsHit [PHASES];
  logic [SAMPLE_W:0] ampMag [PHASES];

  // Serial decode wires
  logic spiRise;
  logic spiFall;
  logic cmdDone;
  pea_addr_t cmdAddr;
  pea_word_t readWord;
  logic energyOn;

  assign energyOn = sampleValid & ~lowPower;
  assign spiRise = spiClk & ~spiClkPrev_r;
  assign spiFall = ~spiClk & spiClkPrev_r;
  assign cmdAddr = {cmdShift_r[ADDR_W-2:0], spiMosi};
  assign cmdDone = (spiState_r == SPI_CMD) & spiRise & (bitCnt_r == CNT_W'(CMD_BITS - 1));

  // Totals take last cycle's values one clock after the cycle closes
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      postCycle_r <= 1'b0;
    end else begin
      postCycle_r <= cycleEnd & ~lowPower;
    end
  end

  genvar p;
  genvar k;
  generate
    for (p = 0; p < PHASES; p++) begin : g_phase
      logic signed [2*SAMPLE_W-1:0] prod [CYCLES];
      logic [SAMPLE_W:0] magV;
      logic [SAMPLE_W:0] magI;
      logic [SAMPLE_W:0] magVf;
      logic [SAMPLE_W:0] magIf;
      logic [2*SAMPLE_W+1:0] magProd;
      logic [2*SAMPLE_W+1:0] magProdF;
      logic signed [ENERGY_W-1:0] fvar;
      logic signed [ENERGY_W-1:0] cw;
      logic signed [ENERGY_W-1:0] cv;

      // Magnitudes widened so that the most negative sample is safe
      assign magV = voltSample[p][SAMPLE_W-1] ?
        (SAMPLE_W+1)'(-$signed({voltSample[p][SAMPLE_W-1], voltSample[p]})) :
        {1'b0, voltSample[p]};
      assign magI = ampSample[p][SAMPLE_W-1] ?
        (SAMPLE_W+1)'(-$signed({ampSample[p][SAMPLE_W-1], ampSample[p]})) :
        {1'b0, ampSample[p]};
      assign magVf = voltFundSample[p][SAMPLE_W-1] ?
        (SAMPLE_W+1)'(-$signed({voltFundSample[p][SAMPLE_W-1], voltFundSample[p]})) :
        {1'b0, voltFundSample[p]};
      assign magIf = ampFundSample[p][SAMPLE_W-1] ?
        (SAMPLE_W+1)'(-$signed({ampFundSample[p][SAMPLE_W-1], ampFundSample[p]})) :
        {1'b0, ampFundSample[p]};
      assign ampMag[p] = magI;
      assign magProd = magV * magI;
      assign magProdF = magVf * magIf;

      // Instantaneous products of one sample
      assign prod[CYC_WATT] = voltSample[p] * ampSample[p];
      assign prod[CYC_VAR] = voltQuadSample[p] * ampSample[p];
      assign prod[CYC_VA] = $signed(magProd[2*SAMPLE_W-1:0]);
      assign prod[CYC_FWATT] = voltFundSample[p] * ampFundSample[p];
      assign prod[CYC_FVAR] = voltFundQuadSample[p] * ampFundSample[p];
      assign prod[CYC_FVA] = $signed(magProdF[2*SAMPLE_W-1:0]);

      for (k = 0; k < CYCLES; k++) begin : g_cyc
        // Scale to the energy LSB
        assign sampleInc[p][k] = ENERGY_W'(prod[k] >>> ENERGY_SHIFT);

        // Running sum restarts each cycle; a sample at the close opens the next
        always_ff @(posedge ref_clk or negedge nrst) begin
          if (!nrst) begin
            sum_r[p][k] <= WORD_RESET;
          end else if (cycleEnd) begin
            sum_r[p][k] <= energyOn ? sampleInc[p][k] : WORD_RESET;
          end else if (energyOn) begin
            sum_r[p][k] <= sum_r[p][k] + sampleInc[p][k];
          end
        end

        // Latch of the completed cycle
        always_ff @(posedge ref_clk or negedge nrst) begin
          if (!nrst) begin
            cyc_r[p][k] <= WORD_RESET;
          end else if (cycleEnd) begin
            cyc_r[p][k] <= sum_r[p][k];
          end
        end
      end

      assign cw = cyc_r[p][CYC_WATT];
      assign cv = cyc_r[p][CYC_VAR];
      assign fvar = cyc_r[p][CYC_FVAR];

      // Sign of the latched real, var and fundamental var cycle values
      logic cwPos;
      logic cwNeg;
      logic cvPos;
      logic cvNeg;
      logic fvarPos;
      logic fvarNeg;
      assign cwPos = (cw > 0);
      assign cwNeg = (cw < 0);
      assign cvPos = (cv > 0);
      assign cvNeg = (cv < 0);
      assign fvarPos = (fvar > 0);
      assign fvarNeg = (fvar < 0);

      // Sign steering of the latched cycle into long-term totals
      assign addEn[p][TOT_WATT_POS] = postCycle_r & cwPos;
      assign incr[p][TOT_WATT_POS] = pea_word_t'(cw);
      assign addEn[p][TOT_WATT_NEG] = postCycle_r & cwNeg;
      assign incr[p][TOT_WATT_NEG] = pea_word_t'(-cw);
      assign addEn[p][TOT_VAR_POS] = postCycle_r & cvPos;
      assign incr[p][TOT_VAR_POS] = pea_word_t'(cv);
      assign addEn[p][TOT_VAR_NEG] = postCycle_r & cvNeg;
      assign incr[p][TOT_VAR_NEG] = pea_word_t'(-cv);
      assign addEn[p][TOT_FVAR_POS] = postCycle_r & fvarPos;
      assign incr[p][TOT_FVAR_POS] = pea_word_t'(fvar);
      assign addEn[p][TOT_FVAR_NEG] = postCycle_r & fvarNeg;
      assign incr[p][TOT_FVAR_NEG] = pea_word_t'(-fvar);
      // Low power counts current magnitude per sample instead of energy
      assign addEn[p][TOT_FVA] = lowPower ? sampleValid : postCycle_r;
      assign incr[p][TOT_FVA] = lowPower ?
        pea_word_t'(ampMag[p]) : pea_word_t'(cyc_r[p][CYC_FVA]);

      for (k = 0; k < TOTALS; k++) begin : g_tot
        pea_acc_if link ();
        assign link.addEn = addEn[p][k];
        assign link.incr = incr[p][k];
        assign total[p][k] = link.total;
        assign overflow[p][k] = link.overflow;
        pea_total_acc u_total (
          .ref_clk(ref_clk),
          .nrst(nrst),
          .port(link.acc)
        );
      end

      // Sticky overflow flags; a wrap in the clearing cycle wins
      logic [TOTALS-1:0] ovfSet;
      for (k = 0; k < TOTALS; k++) begin : g_ovf
        assign ovfSet[k] = overflow[p][k];
      end
      assign flagsHit[p] =
        (cmdAddr == pea_addr_t'(OFF_EXTRA_BASE + pea_addr_t'(p) * OFF_PHASE_STRIDE + OFF_FLAGS));

      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          flags_r[p] <= FLAGS_RESET;
        end else if (cmdDone & flagsHit[p]) begin
          flags_r[p] <= ovfSet;
        end else begin
          flags_r[p] <= flags_r[p] | ovfSet;
        end
      end

      // Read decode of this phase
      pea_addr_t extra;
      assign extra = pea_addr_t'(OFF_EXTRA_BASE + pea_addr_t'(p) * OFF_PHASE_STRIDE);

      // Address hits of this phase
      logic hitCycWatt;
      logic hitCycVar;
      logic hitCycVa;
      logic hitCycFwatt;
      logic hitFvarNeg;
      logic hitFva;
      logic hitWattPos;
      logic hitWattNeg;
      logic hitVarPos;
      logic hitVarNeg;
      logic hitFvarPos;
      logic hitCycFvar;
      logic hitCycFva;
      assign hitCycWatt = (cmdAddr == OFF_CYC_WATT[p]);
      assign hitCycVar = (cmdAddr == OFF_CYC_VAR[p]);
      assign hitCycVa = (cmdAddr == OFF_CYC_VA[p]);
      assign hitCycFwatt = (cmdAddr == OFF_CYC_FWATT[p]);
      assign hitFvarNeg = (cmdAddr == OFF_FVAR_NEG[p]);
      assign hitFva = (cmdAddr == OFF_FVA[p]);
      assign hitWattPos = (cmdAddr == pea_addr_t'(extra + OFF_WATT_POS));
      assign hitWattNeg = (cmdAddr == pea_addr_t'(extra + OFF_WATT_NEG));
      assign hitVarPos = (cmdAddr == pea_addr_t'(extra + OFF_VAR_POS));
      assign hitVarNeg = (cmdAddr == pea_addr_t'(extra + OFF_VAR_NEG));
      assign hitFvarPos = (cmdAddr == pea_addr_t'(extra + OFF_FVAR_POS));
      assign hitCycFvar = (cmdAddr == pea_addr_t'(extra + OFF_CYC_FVAR));
      assign hitCycFva = (cmdAddr == pea_addr_t'(extra + OFF_CYC_FVA));

      assign phaseWord[p] =
        hitCycWatt ? pea_word_t'(cyc_r[p][CYC_WATT]) :
        hitCycVar ? pea_word_t'(cyc_r[p][CYC_VAR]) :
        hitCycVa ? pea_word_t'(cyc_r[p][CYC_VA]) :
        hitCycFwatt ? pea_word_t'(cyc_r[p][CYC_FWATT]) :
        hitFvarNeg ? total[p][TOT_FVAR_NEG] :
        hitFva ? total[p][TOT_FVA] :
        hitWattPos ? total[p][TOT_WATT_POS] :
        hitWattNeg ? total[p][TOT_WATT_NEG] :
        hitVarPos ? total[p][TOT_VAR_POS] :
        hitVarNeg ? total[p][TOT_VAR_NEG] :
        hitFvarPos ? total[p][TOT_FVAR_POS] :
        hitCycFvar ? pea_word_t'(cyc_r[p][CYC_FVAR]) :
        hitCycFva ? pea_word_t'(cyc_r[p][CYC_FVA]) :
        flagsHit[p] ? pea_word_t'(flags_r[p]) :
        WORD_RESET;
    end
  endgenerate

  // Unmapped addresses read as zero
  assign readWord = phaseWord[0] | phaseWord[1] | phaseWord[2];

  // Serial port: 16 command bits in, then 32 data bits out, MSB first
  always_comb begin
    spiState_nxt = spiState_r;
    bitCnt_nxt = bitCnt_r;
    dataShift_nxt = dataShift_r;
    unique case (spiState_r)
      SPI_IDLE: begin
        bitCnt_nxt = '0;
        if (!spiCsN) begin
          spiState_nxt = SPI_CMD;
        end
      end
      SPI_CMD: begin
        if (spiRise) begin
          bitCnt_nxt = bitCnt_r + CNT_W'(1);
        end
        if (cmdDone) begin
          // Whole word captured at once for a coherent read
          dataShift_nxt = readWord;
          spiState_nxt = SPI_DATA;
          bitCnt_nxt = '0;
        end
      end
      SPI_DATA: begin
        if (spiFall) begin
          dataShift_nxt = {dataShift_r[DATA_BITS-2:0], 1'b0};
        end
      end
      default: begin
        spiState_nxt = SPI_IDLE;
      end
    endcase
    if (spiCsN) begin
      spiState_nxt = SPI_IDLE;
      bitCnt_nxt = '0;
    end
  end

  // Serial state and bit count
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      spiState_r <= SPI_IDLE;
      bitCnt_r <= '0;
    end else begin
      spiState_r <= spiState_nxt;
      bitCnt_r <= bitCnt_nxt;
    end
  end

  // Snapshot and shift of the read word
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dataShift_r <= WORD_RESET;
    end else begin
      dataShift_r <= dataShift_nxt;
    end
  end

  // Previous serial clock level for edge detection
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      spiClkPrev_r <= 1'b0;
    end else begin
      spiClkPrev_r <= spiClk;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cmdShift_r <= '0;
    end else if (spiCsN) begin
      cmdShift_r <= '0;
    end else if ((spiState_r == SPI_CMD) & spiRise) begin
      cmdShift_r <= {cmdShift_r[CMD_BITS-2:0], spiMosi};
    end
  end

  // Output pin
  assign spiMiso = dataShift_r[DATA_BITS-1];
  assign spiMisoDrvN = (spiState_r != SPI_DATA);
endmodule
`default_nettype wire

// >>> tb/pea_spi_host.sv
// Host model that reads one 32-bit word per serial transfer.
// Assumes spiClk halves of four ref_clk cycles are slow enough for the device.
`default_nettype none
module pea_spi_host (
  input wire logic ref_clk,
  input wire logic start,
  input wire pea_pkg::pea_addr_t addr,
  output var pea_pkg::pea_word_t data,
  output var logic done,
  output var logic spiClk,
  output var logic spiCsN,
  output var logic spiMosi,
  input wire logic spiMiso,
  input wire logic spiMisoDrvN
);
  timeunit 1ns;
  timeprecision 1ns;
  import pea_pkg::*;
  initial begin : host
    logic [CMD_BITS-1:0] cmd;
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiMosi = 1'b0;
    done = 1'b0;
    data = '0;
    forever begin
      @(posedge ref_clk);
      if (start === 1'b1) begin
        cmd = {4'h0, addr};
        spiCsN <= 1'b0;
        // Command then whole word in one selection
        for (int i = 0; i < CMD_BITS + DATA_BITS - 1; i++) begin
          spiMosi <= (i < CMD_BITS) ? cmd[CMD_BITS-1-i] : ~spiMosi;
          repeat (4) @(posedge ref_clk);
          spiClk <= 1'b1;
          repeat (4) @(posedge ref_clk);
          if (i >= CMD_BITS - 1) data = {data[30:0], spiMisoDrvN ? ~data[0] : spiMiso};
          spiClk <= 1'b0;
        end
        repeat (4) @(posedge ref_clk);
        spiCsN <= 1'b1;
        done <= 1'b1;
        @(posedge ref_clk);
        done <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/pea_energy_top_assertions.sv
// Checker for the serial read port of the energy accumulators.
// Bound to pea_energy_top; sees only its ports.
`default_nettype none
module pea_energy_top_assertions (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cycleEnd,
  input wire logic lowPower,
  input wire logic spiClk,
  input wire logic spiCsN,
  input wire logic spiMiso,
  input wire logic spiMisoDrvN
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sclkPrev_r;
  logic [5:0] riseCnt_r;
  logic [2:0] sinceRise_r;
  logic [2:0] sinceFall_r;
  wire logic sclkRise = spiClk && !sclkPrev_r;
  wire logic sclkFall = !spiClk && sclkPrev_r;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sclkPrev_r <= 1'b0;
      riseCnt_r <= 6'h00;
      sinceRise_r <= 3'h7;
      sinceFall_r <= 3'h7;
    end else begin
      sclkPrev_r <= spiClk;
      riseCnt_r <= spiCsN ? 6'h00 : riseCnt_r + 6'(sclkRise && riseCnt_r != 6'h3f);
      sinceRise_r <= sclkRise ? 3'h0 : sinceRise_r + 3'(sinceRise_r != 3'h7);
      sinceFall_r <= sclkFall ? 3'h0 : sinceFall_r + 3'(sinceFall_r != 3'h7);
    end
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  abort_idle_a: assert property (spiCsN |=> spiMisoDrvN)
    else $error("driver still on after deselect");
  drive_hold_a: assert property (!spiMisoDrvN && !spiCsN |=> !spiMisoDrvN)
    else $error("driver dropped while selected");
  cmd_length_a: assert property ($fell(spiMisoDrvN) |-> riseCnt_r == 6'h10)
    else $error("data phase not after sixteen command bits");
  answer_delay_a: assert property ($fell(spiMisoDrvN) |-> sinceRise_r <= 3'h4)
    else $error("first data bit late");
  drive_select_a: assert property ($fell(spiMisoDrvN) |-> $past(spiCsN, 2) == 1'b0)
    else $error("driver on without selection");
  data_window_a: assert property (!spiMisoDrvN |-> riseCnt_r >= 6'h10)
    else $error("driver on during command");
  bit_stable_a: assert property (!spiMisoDrvN && $past(spiMisoDrvN) == 1'b0 &&
    $changed(spiMiso) |-> sinceFall_r <= 3'h4) else $error("data bit moved off a fall");
  reset_idle_a: assert property ($rose(nrst) |-> spiMisoDrvN && !spiMiso)
    else $error("serial output not idle out of reset");
  cover property ($fell(spiMisoDrvN));
  cover property (cycleEnd && lowPower);
  cover property (spiCsN && !spiMisoDrvN);
endmodule
bind pea_energy_top pea_energy_top_assertions chk (.ref_clk(ref_clk), .nrst(nrst),
  .cycleEnd(cycleEnd), .lowPower(lowPower), .spiClk(spiClk), .spiCsN(spiCsN),
  .spiMiso(spiMiso), .spiMisoDrvN(spiMisoDrvN));
`default_nettype wire

// >>> tb/pea_energy_top_bench.sv
// Self-checking bench for the per-phase energy accumulators.
// Assumes the host model drives the serial port and the checker is bound.
`default_nettype none
module pea_energy_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import pea_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic sampleValid = 1'b0;
  logic cycleEnd = 1'b0;
  logic lowPower = 1'b0;
  logic start = 1'b0;
  logic spiClk, spiCsN, spiMosi, spiMiso, spiMisoDrvN, hostDone;
  pea_addr_t hostAddr = 12'h000;
  pea_word_t hostData;
  pea_sample_t volt [PHASES] = '{default: 16'h0000}, amp [PHASES] = '{default: 16'h0000};
  pea_sample_t quad [PHASES] = '{default: 16'h0000}, fquad [PHASES] = '{default: 16'h0000};
  int mismatches = 0;
  int check_count = 0;
  pea_energy_top dut (.ref_clk(ref_clk), .nrst(nrst), .sampleValid(sampleValid),
    .cycleEnd(cycleEnd), .lowPower(lowPower), .voltSample(volt), .ampSample(amp),
    .voltQuadSample(quad), .voltFundSample(volt), .ampFundSample(amp),
    .voltFundQuadSample(fquad), .spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoDrvN(spiMisoDrvN));
  pea_spi_host host (.ref_clk(ref_clk), .start(start), .addr(hostAddr), .data(hostData),
    .done(hostDone), .spiClk(spiClk), .spiCsN(spiCsN), .spiMosi(spiMosi),
    .spiMiso(spiMiso), .spiMisoDrvN(spiMisoDrvN));
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    tick(6);
    nrst <= 1'b1;
    tick(1);
  endtask
  function automatic pea_addr_t ex(input int p, input pea_addr_t off);
    return pea_addr_t'(OFF_EXTRA_BASE + p * OFF_PHASE_STRIDE + off);
  endfunction
  task automatic read_check(input pea_addr_t addr, input pea_word_t expv);
    int w;
    w = 0;
    start <= 1'b1;
    hostAddr <= addr;
    do begin
      tick(1);
      w++;
    end while (hostDone !== 1'b1 && w < 1000);
    start <= 1'b0;
    if (hostDone !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t read %h timed out", $time, addr);
    end
    check_count++;
    if (hostData !== expv) begin
      mismatches++;
      $display("ERROR %0t read %h got %h want %h", $time, addr, hostData, expv);
    end
    tick(1);
  endtask
  task automatic set_phase(input int p, input pea_sample_t v, q, fq, i);
    volt[p] <= v;
    quad[p] <= q;
    fquad[p] <= fq;
    amp[p] <= i;
  endtask
  task automatic run_cycle(input int n);
    repeat (n) begin
      sampleValid <= 1'b1;
      tick(1);
    end
    sampleValid <= 1'b0;
    cycleEnd <= 1'b1;
    tick(1);
    cycleEnd <= 1'b0;
    tick(3);
  endtask
  task automatic t_idle();
    do_reset();
    read_check(12'h000, 32'h0000_0000);
    read_check(ex(2, OFF_FLAGS), 32'h0000_0000);
    read_check(OFF_FVA[2], 32'h0000_0000);
  endtask
  task automatic t_lowpower();
    do_reset();
    set_phase(0, 16'h4000, 16'h4000, 16'h4000, 16'hedcc);
    set_phase(1, 16'h4000, 16'h4000, 16'h4000, 16'h0100);
    lowPower <= 1'b1;
    run_cycle(5);
    lowPower <= 1'b0;
    read_check(OFF_FVA[0], 32'h0000_5b04);
    read_check(OFF_FVA[1], 32'h0000_0500);
    read_check(OFF_CYC_WATT[0], 32'h0000_0000);
    read_check(ex(0, OFF_VAR_POS), 32'h0000_0000);
  endtask
  task automatic t_signed();
    pea_word_t e;
    pea_word_t e2;
    do_reset();
    for (int p = 0; p < PHASES; p++) set_phase(p, 16'h4000, 16'hc000, 16'hc000, 16'(16'h1000 << p));
    run_cycle(3);
    for (int p = 0; p < PHASES; p++) begin
      e = 32'h3000 << p;
      read_check(OFF_CYC_WATT[p], e);
      read_check(OFF_CYC_VAR[p], -e);
      read_check(OFF_CYC_VA[p], e);
      read_check(OFF_CYC_FWATT[p], e);
      read_check(OFF_FVAR_NEG[p], e);
      read_check(ex(p, OFF_WATT_POS), e);
      read_check(ex(p, OFF_VAR_NEG), e);
    end
    for (int p = 0; p < PHASES; p++) set_phase(p, 16'hc000, 16'h4000, 16'h4000, 16'(16'h1000 << p));
    run_cycle(2);
    for (int p = 0; p < PHASES; p++) begin
      e = 32'h3000 << p;
      e2 = 32'h2000 << p;
      read_check(OFF_FVA[p], e + e2);
      read_check(ex(p, OFF_WATT_NEG), e2);
      read_check(ex(p, OFF_VAR_POS), e2);
      read_check(ex(p, OFF_FVAR_POS), e2);
      read_check(ex(p, OFF_CYC_FVAR), e2);
      read_check(ex(p, OFF_CYC_FVA), e2);
      read_check(ex(p, OFF_WATT_POS), e);
    end
  endtask
  task automatic t_overflow();
    do_reset();
    set_phase(0, 16'h8000, 16'h8000, 16'h8000, 16'h8000);
    set_phase(1, 16'h8000, 16'h8000, 16'h7fff, 16'h8000);
    set_phase(2, 16'h0000, 16'h0000, 16'h0000, 16'h0000);
    repeat (4) run_cycle(16384);
    run_cycle(4);
    read_check(ex(0, OFF_FLAGS), 32'h0000_0055);
    read_check(ex(0, OFF_FLAGS), 32'h0000_0000);
    read_check(ex(0, OFF_WATT_POS), 32'h0004_0000);
    read_check(ex(1, OFF_FLAGS), 32'h0000_0065);
    read_check(OFF_FVAR_NEG[1], 32'h0001_fff8);
    read_check(ex(2, OFF_FLAGS), 32'h0000_0000);
  endtask
  task automatic summarize();
    if (mismatches == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge ref_clk);
    mismatches++;
    summarize();
  end
  initial begin
    t_idle();
    t_lowpower();
    t_signed();
    t_overflow();
    summarize();
  end
endmodule
`default_nettype wire
